// [src/radio_config_spi_slave.sv]
// Purpose: four-wire SPI slave for radio configuration and transmit buffer
// Assumes: SPI mode 0, sclk from host is a clock of its own
// Notes: registers live in the sclk domain; status comes from core domain
`timescale 1ns/1ps
module radio_config_spi_slave
  import radio_spi_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // SPI link; inputs in sclk domain, miso outputs registered on core clock
  input wire logic spi_clk_in,
  input wire logic chip_select_low_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  // Radio state from core
  input wire logic crystal_running_in,
  input wire logic asleep_in,
  input wire logic [2:0] main_state_in,
  input wire logic [6:0] tx_free_in,
  input wire logic [7:0] status_reg_data_in,
  // Register readback port, core domain
  input wire logic [5:0] cfg_sel_in,
  output logic [7:0] cfg_data_out,
  // Core-side events
  output logic strobe_valid_out,
  output logic [5:0] strobe_code_out,
  output logic txbuf_valid_out,
  output logic [7:0] txbuf_data_out
);
  // Link-domain state
  logic [7:0] cfg_mem [NUM_CFG];        // Configuration registers
  logic [2:0] bit_cnt_r, bit_cnt_nxt;   // Bit within byte
  logic [7:0] shin_r, shin_nxt;         // Incoming shift register
  header_s hdr_r, hdr_nxt;              // Latched header
  phase_e ph_r, ph_nxt;                 // Header or data byte
  logic [5:0] addr_r, addr_nxt;         // Burst address counter
  logic [7:0] shout_r, shout_nxt;       // Outgoing byte
  logic ev_tog_r, ev_tog_nxt;           // Event toggle to core
  logic [7:0] ev_data_r, ev_data_nxt;   // Event payload
  logic ev_is_strobe_r, ev_is_strobe_nxt;
  logic [5:0] ev_code_r, ev_code_nxt;
  logic cfg_we;                          // Register write strobe
  logic link_rst_n_r;                    // Core reset seen in link domain
  logic link_rst_meta_r;
  logic [7:0] rd_byte;                   // Read data selected
  status_s stat_link;                    // Status seen by link
  logic [7:0] stat_meta_r, stat_sync_r;  // Status crossing
  logic [7:0] byte_in;                   // Byte just completed
  logic [7:0] shout_hold_r;              // Next byte, loaded at boundary
  logic first_r;                         // First falling edge since select

  // Map radio state to status fields
  function automatic status_s make_status(input logic rdy, input logic [2:0] st,
                                          input logic [6:0] fr);
    status_s s;
    s.crystal_not_ready_flag = ~rdy;
    s.state = st;
    s.free_bytes = (fr >= 7'(FREE_SAT)) ? FREE_SAT : fr[3:0];
    return s;
  endfunction

  // Address classes used in several places
  function automatic logic is_cfg(input logic [5:0] a);
    return a <= CFG_LAST;
  endfunction

  // Link reset: released through two stages, slow path is fine
  always_ff @(posedge spi_clk_in) begin
    link_rst_meta_r <= reset_n_in;
    link_rst_n_r <= link_rst_meta_r;
  end

  // Status staged in the core domain; the link reads it as a quasi-static
  // byte, since sclk stands still between frames and cannot refresh it
  always_ff @(posedge core_clk_in) begin
    stat_meta_r <= make_status(crystal_running_in, main_state_in, tx_free_in);
    stat_sync_r <= stat_meta_r;
  end
  assign stat_link = status_s'(stat_sync_r);

  assign byte_in = {shin_r[6:0], mosi_in};
  assign rd_byte = is_cfg(addr_r) ? cfg_mem[addr_r] : status_reg_data_in;

  // Next-state of the link shifter; cs high holds bit count, phase and shifter at start
  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 3'h1;
    shin_nxt = byte_in;
    hdr_nxt = hdr_r;
    ph_nxt = ph_r;
    addr_nxt = addr_r;
    shout_nxt = {shout_r[6:0], 1'b0};
    ev_tog_nxt = ev_tog_r;
    ev_data_nxt = ev_data_r;
    ev_is_strobe_nxt = ev_is_strobe_r;
    ev_code_nxt = ev_code_r;
    cfg_we = 1'b0;
    if (bit_cnt_r == BIT_LAST) begin
      shout_nxt = stat_link;
      unique case (ph_r)
        PH_HEADER: begin
          hdr_nxt = header_s'(byte_in);
          addr_nxt = byte_in[5:0];
          ph_nxt = PH_DATA;
          if (byte_in[5:0] >= CMD_FIRST && byte_in[5:0] <= CMD_LAST
              && !byte_in[HDR_BURST]) begin
            // Strobe: no data byte follows
            ph_nxt = PH_HEADER;
            // Crystal-stop is dropped; power-down is held in the core
            if (byte_in[5:0] != STROBE_CRYSTAL_OFF_STATE) begin
              ev_tog_nxt = ~ev_tog_r;
              ev_is_strobe_nxt = 1'b1;
              ev_code_nxt = byte_in[5:0];
            end
          end
          if (byte_in[HDR_RW]) begin
            // Reads return data, not status
            shout_nxt = is_cfg(byte_in[5:0]) ? cfg_mem[byte_in[5:0]]
                        : status_reg_data_in;
          end
        end
        PH_DATA: begin
          if (!hdr_r.is_read && is_cfg(addr_r))
            cfg_we = 1'b1;
          if (!hdr_r.is_read && addr_r == TXBUF_ADDR) begin
            ev_tog_nxt = ~ev_tog_r;
            ev_is_strobe_nxt = 1'b0;
            ev_data_nxt = byte_in;
          end
          if (hdr_r.burst && is_cfg(addr_r)) begin
            addr_nxt = addr_r + 6'h1;
            if (hdr_r.is_read)
              shout_nxt = is_cfg(addr_r + 6'h1) ? cfg_mem[addr_r + 6'h1]
                          : CFG_RESET;
          end else if (hdr_r.burst && addr_r == TXBUF_ADDR) begin
            ph_nxt = PH_DATA;
          end else begin
            ph_nxt = PH_HEADER;
          end
        end
        default: ph_nxt = PH_HEADER;
      endcase
    end
  end

  // Link registers; async cs clears the byte in flight
  always_ff @(posedge spi_clk_in or posedge chip_select_low_in) begin
    if (chip_select_low_in) begin
      bit_cnt_r <= 3'h0;
      ph_r <= PH_HEADER;
      shin_r <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      ph_r <= ph_nxt;
      shin_r <= shin_nxt;
    end
  end

  // Link registers not cancelled by cs
  always_ff @(posedge spi_clk_in) begin
    if (!link_rst_n_r) begin
      hdr_r <= '0;
      addr_r <= 6'h00;
      ev_tog_r <= 1'b0;
      ev_data_r <= 8'h00;
      ev_is_strobe_r <= 1'b0;
      ev_code_r <= 6'h00;
    end else begin
      hdr_r <= hdr_nxt;
      addr_r <= addr_nxt;
      ev_tog_r <= ev_tog_nxt;
      ev_data_r <= ev_data_nxt;
      ev_is_strobe_r <= ev_is_strobe_nxt;
      ev_code_r <= ev_code_nxt;
    end
  end

  // Register file, one loop per address
  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge spi_clk_in) begin
      if (!link_rst_n_r)
        cfg_mem[i] <= CFG_RESET;
      else if (cfg_we && addr_r == 6'(i))
        cfg_mem[i] <= byte_in;
    end
  end

  // Output shifts on falling edge so the host samples on rising
  always_ff @(negedge spi_clk_in or posedge chip_select_low_in) begin
    if (chip_select_low_in) begin
      // Bit 7 of the first status reads low: host only clocks once ready
      shout_r <= 8'h00;
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
      if (bit_cnt_r == 3'h0)
        shout_r <= shout_hold_r;
      else if (first_r)
        shout_r <= {stat_link[6:0], 1'b0};
      else
        shout_r <= {shout_r[6:0], 1'b0};
    end
  end
  // Hold the assembled byte for the next falling edge
  always_ff @(posedge spi_clk_in) shout_hold_r <= shout_nxt;

  // Core side: synchronise cs and toggle
  logic cs_meta_r, cs_sync_r, cs_prev_r;
  logic tog_meta_r, tog_sync_r, tog_prev_r;
  logic pend_pwd_r, pend_pwd_nxt;
  logic miso_nxt, miso_oe_nxt;
  logic strobe_v_nxt, txbuf_v_nxt;
  logic [5:0] strobe_c_nxt;
  logic [7:0] txbuf_d_nxt;

  // Core next values: pin, strobes, buffer writes
  always_comb begin
    miso_nxt = 1'b1;
    miso_oe_nxt = 1'b0;
    strobe_v_nxt = 1'b0;
    strobe_c_nxt = strobe_code_out;
    txbuf_v_nxt = 1'b0;
    txbuf_d_nxt = txbuf_data_out;
    pend_pwd_nxt = pend_pwd_r;
    if (!cs_sync_r) begin
      miso_oe_nxt = 1'b1;
      // Low at once unless asleep or crystal stopped
      miso_nxt = asleep_in | ~crystal_running_in;
      if (cs_prev_r == cs_sync_r && !cs_sync_r)
        miso_nxt = shout_r[7];
    end
    if (tog_sync_r != tog_prev_r) begin
      if (ev_is_strobe_r && ev_code_r == STROBE_PWD) begin
        pend_pwd_nxt = 1'b1;
      end else if (ev_is_strobe_r) begin
        strobe_v_nxt = 1'b1;
        strobe_c_nxt = ev_code_r;
      end else begin
        txbuf_v_nxt = 1'b1;
        txbuf_d_nxt = ev_data_r;
      end
    end
    // Deferred strobes fire on cs rise
    // Pending flag may arrive in the same cycle as the rise
    if (cs_sync_r && !cs_prev_r && pend_pwd_nxt) begin
      strobe_v_nxt = 1'b1;
      strobe_c_nxt = STROBE_PWD;
      pend_pwd_nxt = 1'b0;
    end
  end

  // Core registers
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_prev_r <= 1'b0;
      pend_pwd_r <= 1'b0;
      miso_out <= 1'b1;
      miso_oe_out <= 1'b0;
      strobe_valid_out <= 1'b0;
      strobe_code_out <= 6'h00;
      txbuf_valid_out <= 1'b0;
      txbuf_data_out <= 8'h00;
      cfg_data_out <= 8'h00;
    end else begin
      cs_meta_r <= chip_select_low_in;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      tog_meta_r <= ev_tog_r;
      tog_sync_r <= tog_meta_r;
      tog_prev_r <= tog_sync_r;
      pend_pwd_r <= pend_pwd_nxt;
      miso_out <= miso_nxt;
      miso_oe_out <= miso_oe_nxt;
      strobe_valid_out <= strobe_v_nxt;
      strobe_code_out <= strobe_c_nxt;
      txbuf_valid_out <= txbuf_v_nxt;
      txbuf_data_out <= txbuf_d_nxt;
      cfg_data_out <= is_cfg(cfg_sel_in) ? cfg_mem[cfg_sel_in] : CFG_RESET;
    end
  end

  // Assertions on the core domain, except the status saturation check on sclk
  property p_float_deselect;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      cs_sync_r |=> !miso_oe_out;
  endproperty
  a_float_deselect: assert property (p_float_deselect)
    else $error("data out driven while deselected");

  property p_low_on_select;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      (!cs_sync_r && cs_prev_r && crystal_running_in && !asleep_in)
        |=> (miso_oe_out && !miso_out);
  endproperty
  a_low_on_select: assert property (p_low_on_select)
    else $error("data out not low after select");

  property p_one_shot_strobe;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      strobe_valid_out |=> !strobe_valid_out;
  endproperty
  a_one_shot_strobe: assert property (p_one_shot_strobe)
    else $error("strobe pulse longer than a cycle");

  property p_strobe_code;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      strobe_valid_out |-> (strobe_code_out >= CMD_FIRST
        && strobe_code_out <= CMD_LAST && strobe_code_out != STROBE_CRYSTAL_OFF_STATE);
  endproperty
  a_strobe_code: assert property (p_strobe_code)
    else $error("strobe code outside strobe range");

  property p_one_shot_buf;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      txbuf_valid_out |=> !txbuf_valid_out;
  endproperty
  a_one_shot_buf: assert property (p_one_shot_buf)
    else $error("buffer write pulse longer than a cycle");

  property p_status_sat;
    @(posedge spi_clk_in) disable iff (!link_rst_n_r)
      stat_link.free_bytes <= FREE_SAT;
  endproperty
  a_status_sat: assert property (p_status_sat)
    else $error("free count out of range");

  c_strobe: cover property (@(posedge core_clk_in) strobe_valid_out);
  c_buf: cover property (@(posedge core_clk_in) txbuf_valid_out);
  c_select: cover property (@(posedge core_clk_in)
    !cs_sync_r && cs_prev_r);
endmodule

// [include/radio_spi_pkg.sv]
// Purpose: shared constants and types for the radio configuration SPI slave
// Assumes: byte-wide registers, 6-bit header address
// Notes: status byte layout and address map live here
package radio_spi_pkg;
  localparam int ADDR_W = 6;
  localparam int NUM_CFG = 47;                 // Registers 0x00..0x2e
  localparam logic [5:0] CFG_LAST = 6'h2e;
  localparam logic [5:0] CMD_FIRST = 6'h30;
  localparam logic [5:0] CMD_LAST = 6'h3d;
  localparam logic [5:0] TXBUF_ADDR = 6'h3f;
  localparam logic [5:0] STROBE_PWD = 6'h39;
  localparam logic [5:0] STROBE_CRYSTAL_OFF_STATE = 6'h32;
  localparam logic [5:0] STROBE_RES = 6'h30;
  localparam logic [5:0] STROBE_FTX = 6'h3b;
  localparam logic [7:0] CFG_RESET = 8'h00;    // Default register value
  localparam int HDR_RW = 7;                   // Read/write bit
  localparam int HDR_BURST = 6;                // Burst bit
  localparam logic [2:0] BIT_LAST = 3'h7;      // Bit counter at last bit
  localparam logic [2:0] ST_IDLE = 3'h0;
  localparam logic [2:0] ST_SYNTH_ON = 3'h3;
  localparam logic [2:0] ST_CALIB = 3'h4;
  localparam logic [2:0] ST_SETTLE = 3'h5;
  localparam logic [2:0] ST_UNDERRUN = 3'h7;
  localparam logic [3:0] FREE_SAT = 4'hf;

  typedef struct packed {
    logic crystal_not_ready_flag;
    logic [2:0] state;
    logic [3:0] free_bytes;
  } status_s;

  typedef struct packed {
    logic is_read;
    logic burst;
    logic [5:0] addr;
  } header_s;

  typedef enum logic [1:0] {PH_HEADER, PH_DATA, PH_SKIP} phase_e;
endpackage

// [tb/spi_host_model.sv]
// Purpose: SPI master model standing in for the host controller
// Assumes: mode 0, data changes after a falling edge, sampled on rising
// Notes: clock stands still outside frames except idle_pulses at reset; half period set per test
`timescale 1ns/1ps
module spi_host_model (
  // SPI pins toward the slave
  output logic spi_clk_out,
  output logic chip_select_low_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  realtime half_ns = 24.0; // Fast link by default

  // Idle levels at time zero
  initial begin
    spi_clk_out = 1'b0;
    chip_select_low_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Pulses with select high, only so the link domain sees reset
  task automatic idle_pulses(input int n);
    repeat (n) begin
      #half_ns spi_clk_out = 1'b1;
      #half_ns spi_clk_out = 1'b0;
    end
  endtask

  // Select, then hold off clocking until data out reads low
  task automatic select(output bit ok);
    int i;
    chip_select_low_out = 1'b0;
    ok = 1'b0;
    for (i = 0; i < 50 && !ok; i++) begin
      #50;
      ok = (miso_oe_in === 1'b1) && (miso_in === 1'b0);
    end
  endtask

  // Shift n bits, top bit first; slow half period needed for readback
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 7; i > 7 - n; i--) begin
      mosi_out = tx[i];
      #half_ns spi_clk_out = 1'b1;
      rx[i] = miso_in;
      #half_ns spi_clk_out = 1'b0;
    end
  endtask

  // End of frame; released data line shows inverse of its last bit
  task automatic deselect();
    #half_ns chip_select_low_out = 1'b1;
    mosi_out = ~mosi_out;
  endtask
endmodule

// [tb/radio_config_spi_slave_test.sv]
// Purpose: self-checking bench for the radio configuration SPI slave
// Assumes: core inputs change on the falling core clock edge
// Notes: readback frames run a slow link clock, miso is resynchronised
`timescale 1ns/1ps
module radio_config_spi_slave_test;
  import radio_spi_pkg::*;
  logic core_clk_in, reset_n_in, spi_clk, chip_select_low, mosi;
  logic miso, miso_oe, crystal_running, asleep, strobe_valid, txbuf_valid;
  logic [2:0] main_state;
  logic [6:0] tx_free;
  logic [7:0] stat_data, cfg_data, txbuf_data;
  logic [5:0] cfg_sel, strobe_code;
  int n_fail = 0;
  int n_compared = 0;
  logic [7:0] tx_q[$], rx_q[$], ev_strobe[$], ev_buf[$];
  logic [2:0] st[5] = '{ST_IDLE, ST_SYNTH_ON, ST_CALIB, ST_SETTLE,
                        ST_UNDERRUN};
  logic [7:0] bx[4] = '{8'ha1, 8'hb1, 8'hb2, 8'hb3};

  radio_config_spi_slave i_dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .spi_clk_in(spi_clk), .chip_select_low_in(chip_select_low),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
    .crystal_running_in(crystal_running), .asleep_in(asleep),
    .main_state_in(main_state), .tx_free_in(tx_free),
    .status_reg_data_in(stat_data), .cfg_sel_in(cfg_sel),
    .cfg_data_out(cfg_data), .strobe_valid_out(strobe_valid),
    .strobe_code_out(strobe_code), .txbuf_valid_out(txbuf_valid),
    .txbuf_data_out(txbuf_data));
  spi_host_model i_host (
    .spi_clk_out(spi_clk), .chip_select_low_out(chip_select_low),
    .mosi_out(mosi), .miso_in(miso), .miso_oe_in(miso_oe));

  // 20 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  // Log one-cycle event pulses so no pulse is missed
  always @(posedge core_clk_in) begin
    if (strobe_valid === 1'b1)
      ev_strobe.push_back({2'b00, strobe_code});
    if (txbuf_valid === 1'b1)
      ev_buf.push_back(txbuf_data);
  end

  // Byte compare, used for flags too after zero extension
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    n_compared++;
    if (act !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // One frame of tx_q; last byte cut to last_bits for aborts
  task automatic frame(input int last_bits);
    bit ok;
    logic [7:0] rx;
    int i;
    rx_q = {};
    i_host.select(ok);
    cmp8({7'h00, ok}, 8'h01);
    for (i = 0; i < tx_q.size(); i++) begin
      i_host.shift(tx_q[i], (i == tx_q.size() - 1) ? last_bits : 8, rx);
      rx_q.push_back(rx);
    end
    i_host.deselect();
    repeat (12) @(negedge core_clk_in);
    cmp8({7'h00, miso_oe}, 8'h00);
  endtask

  // Core-side readback, registered one cycle
  task automatic cfg_chk(input logic [5:0] a, input logic [7:0] e);
    @(negedge core_clk_in);
    cfg_sel = a;
    repeat (2) @(negedge core_clk_in);
    cmp8(cfg_data, e);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, n_fail);
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, well beyond the expected run of about 0.2 ms
  initial begin
    #3ms;
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [6:0] f;
    int i;
    reset_n_in = 1'b0;
    crystal_running = 1'b1;
    asleep = 1'b0;
    main_state = ST_IDLE;
    tx_free = 7'h40;
    stat_data = 8'h5a;
    cfg_sel = 6'h00;
    i_host.idle_pulses(3);
    repeat (10) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    cmp8({7'h00, miso_oe}, 8'h00);
    for (i = 0; i < NUM_CFG; i++)
      cfg_chk(6'(i), CFG_RESET);
    end_test("reset");
    // Five of the eight state codes, free count crossing saturation
    i_host.half_ns = 600.0;
    for (i = 0; i < 5; i++) begin
      f = 7'(i * 4 + 3);
      main_state = st[i];
      tx_free = f;
      repeat (4) @(negedge core_clk_in);
      tx_q = '{8'(i + 1), 8'(8'h10 + i)};
      frame(8);
      cmp8(rx_q[0], {1'b0, st[i], (f > 15) ? FREE_SAT : f[3:0]});
      cmp8(rx_q[1], {1'b0, st[i], (f > 15) ? FREE_SAT : f[3:0]});
      cfg_chk(6'(i + 1), 8'(8'h10 + i));
    end
    tx_q = '{8'h82, 8'h00};
    frame(8);
    cmp8(rx_q[1], 8'h11);
    tx_q = '{8'hf5, 8'h00};
    frame(8);
    cmp8(rx_q[1], 8'h5a);
    end_test("status and read");
    // Burst write up to the top register, slow burst read back
    main_state = ST_IDLE;
    i_host.half_ns = 24.0;
    tx_q = '{8'h6c, 8'h11, 8'h22, 8'h33};
    frame(8);
    for (i = 0; i < 3; i++)
      cfg_chk(6'(8'h2c + i), 8'(8'h11 * (i + 1)));
    i_host.half_ns = 600.0;
    tx_q = '{8'hed, 8'h00, 8'h00};
    frame(8);
    cmp8(rx_q[1], 8'h22);
    cmp8(rx_q[2], 8'h33);
    end_test("burst");
    // Aborted data byte and aborted header leave nothing behind
    i_host.half_ns = 24.0;
    tx_q = '{8'h06, 8'hff};
    frame(4);
    cfg_chk(6'h06, CFG_RESET);
    tx_q = '{8'h3b};
    frame(5);
    cmp8(8'(ev_strobe.size()), 8'h00);
    end_test("abort");
    tx_q = '{8'h3f, 8'ha1};
    frame(8);
    tx_q = '{8'h7f, 8'hb1, 8'hb2, 8'hb3};
    frame(8);
    cmp8(8'(ev_buf.size()), 8'h04);
    for (i = 0; i < ev_buf.size() && i < 4; i++)
      cmp8(ev_buf[i], bx[i]);
    end_test("transmit buffer");
    // Each strobe alone; crystal-stop is dropped by design choice
    for (i = CMD_FIRST; i <= CMD_LAST; i++) begin
      ev_strobe = {};
      tx_q = '{8'(i)};
      frame(8);
      cmp8(8'(ev_strobe.size()), (i == STROBE_CRYSTAL_OFF_STATE) ? 8'h00 : 8'h01);
      if (ev_strobe.size() > 0)
        cmp8(ev_strobe[0], 8'(i));
    end
    end_test("strobes");
    report_and_stop();
  end
endmodule
